// ### bee_dev_model.sv
`default_nettype none
module bee_dev_model #(
  parameter int WR_CYC = 30,
  parameter int PON_CYC = 40,
  parameter int CLR_CYC = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic [10:0] a,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic oe_hv,
  input wire logic we_n,
  input wire logic address_pin_nine_hv,
  input wire logic [7:0] dq,
  output logic drv,
  output logic [7:0] q,
  output logic rdy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:2079];
  logic [11:0] wa;
  logic [7:0] wd;
  logic lo_q;
  int bc, pc, cc;
  wire lo = !cs_n && !we_n && oe_n && !oe_hv;
  wire [11:0] idx = (address_pin_nine_hv && a >= 11'h7e0) ? 12'h800 + a[4:0] : {1'b0, a};
  assign drv = !cs_n && !oe_n && we_n;
  // low bits count down while busy and not stalled, so a stale poll never looks like data
  assign q = (bc > 0) ? {~wd[7], bc[6:0]} : mem[idx];
  assign rdy = !(bc > 0);
  initial for (int i = 0; i < 2080; i++) mem[i] = 8'h00;
  always @(posedge clk) begin
    lo_q <= lo;
    if (reset) begin
      bc <= 0;
      pc <= PON_CYC;
      cc <= 0;
    end else begin
      cc <= (!cs_n && !we_n && oe_hv) ? cc + 1 : 0;
      if (cc == CLR_CYC) for (int i = 0; i < 2080; i++) mem[i] <= 8'hff;
      if (pc > 0) pc <= pc - 1;
      if (lo && !lo_q) wa <= idx;
      if (lo) wd <= dq;
      if (!lo && lo_q && pc == 0 && bc == 0) begin
        mem[wa] <= wd;
        bc <= WR_CYC;
      end else if (bc > 0 && !stall) bc <= bc - 1;
    end
  end
endmodule // bee_dev_model
`default_nettype wire

// ### bee_host.sv
// Operation
// - write is strobe low, select low, gate high
// - host detects end via busy or polling
// - gate at 12 V plus 10 ms strobe clears
// - address pin nine high reaches id area
`include "bee_map.svh"
`default_nettype none
module bee_host #(
  parameter int unsigned POWER_ON_CYC = (`BEE_POWER_ON_US * (`BEE_CLK_HZ / 1000000)),
  parameter int unsigned WRITE_MAX_CYC = (`BEE_WRITE_CYCLE_US * (`BEE_CLK_HZ / 1000000)),
  parameter int unsigned CLEAR_CYC = (`BEE_CLEAR_PULSE_US * (`BEE_CLK_HZ / 1000000)),
  parameter bit USE_BUSY_PIN = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire bee_pkg::bee_op_t req_op,
  input wire logic req_id_area,
  input wire logic [10:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_timeout,
  output logic mem_addr,
  output logic [10:0] mem_a,
  output logic mem_chip_sel_n,
  output logic mem_out_gate_n,
  output logic mem_out_gate_hv,
  output logic mem_wr_strobe_n,
  output logic mem_address_pin_nine_hv,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [7:0] mem_dq_i,
  input wire logic mem_ready_busy_n
);
  import bee_pkg::*;
  localparam int unsigned RD_CYC = (`BEE_READ_ACCESS_NS * (`BEE_CLK_HZ / 1000000) + 999) / 1000 + 1;
  localparam int unsigned WP_CYC = (`BEE_WRITE_PULSE_NS * (`BEE_CLK_HZ / 1000000) + 999) / 1000;
  localparam int CW = 32;

  bee_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, wait_q;
  logic [7:0] dq_s1_q, dq_s2_q, wdata_q;
  logic rb_s1_q, rb_s2_q;
  logic por_done_q, wr_timed_q;
  logic [10:0] a_q;
  logic idsel_q;
  logic [CW-1:0] wd_q;
  logic wd_hit_q;

  function automatic logic [CW-1:0] to_cw(input int unsigned v);
    return CW'(v);
  endfunction

  // two flops on every pin input; nothing reads the first
  always_ff @(posedge clk) begin
    dq_s1_q <= mem_dq_i;
    dq_s2_q <= dq_s1_q;
    rb_s1_q <= mem_ready_busy_n;
    rb_s2_q <= rb_s1_q;
  end

  // no write until the power-on delay has elapsed; also ramp
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= '0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      wait_q <= wait_q + 1'b1;
      por_done_q <= (wait_q >= to_cw(POWER_ON_CYC) - 1'b1);
    end
  end

  // poll reads true msb when programming finished
  wire poll_done = (dq_s2_q[`BEE_MSB] == wdata_q[`BEE_MSB]);
  wire busy_done = rb_s2_q;
  wire end_seen = USE_BUSY_PIN ? busy_done : poll_done;
  wire cnt_zero = (cnt_q == '0);
  wire wr_ok = por_done_q;
  wire take = req_valid && req_ready;

  always_comb begin
    state_d = state_q;
    case (state_q)
      BEE_IDLE: begin
        if (take) begin
          case (req_op)
            BEE_OP_READ: state_d = BEE_RD;
            BEE_OP_WRITE: state_d = BEE_WR;
            BEE_OP_CLEAR: state_d = BEE_CLR;
            default: state_d = BEE_IDLE;
          endcase
        end
      end
      BEE_RD: if (cnt_zero) state_d = BEE_DONE;
      BEE_WR: if (cnt_zero) state_d = BEE_WAIT;
      BEE_WAIT: if (cnt_zero) state_d = BEE_POLL;
      BEE_POLL: if (cnt_zero && (end_seen || wr_timed_q)) state_d = BEE_DONE;
      BEE_CLR: if (cnt_zero) state_d = BEE_WAIT;
      BEE_DONE: state_d = BEE_IDLE;
      default: state_d = BEE_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= BEE_IDLE;
      cnt_q <= '0;
      wr_timed_q <= 1'b0;
      wdata_q <= 8'h00;
      a_q <= 11'h000;
      idsel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        a_q <= req_addr;
        wdata_q <= req_wdata;
        idsel_q <= req_id_area;
      end
      if (!cnt_zero) cnt_q <= cnt_q - 1'b1;
      case (state_d)
        BEE_RD: if (state_q == BEE_IDLE) cnt_q <= to_cw(RD_CYC);
        BEE_WR: if (state_q == BEE_IDLE) cnt_q <= to_cw(WP_CYC);
        BEE_CLR: if (state_q == BEE_IDLE) cnt_q <= to_cw(CLEAR_CYC);
        BEE_WAIT: if (state_q != BEE_WAIT) cnt_q <= to_cw(RD_CYC);
        // device ends within the write cycle limit; then give up waiting
        BEE_POLL: if (state_q == BEE_WAIT) cnt_q <= to_cw(RD_CYC);
        default: ;
      endcase
      if (state_q == BEE_POLL && cnt_zero && !(end_seen || wr_timed_q)) cnt_q <= to_cw(RD_CYC);
      if (state_q == BEE_WAIT && state_d == BEE_POLL) wr_timed_q <= 1'b0;
      else if (state_q == BEE_POLL && wd_hit_q) wr_timed_q <= 1'b1;
    end
  end

  // write watchdog, separate counter so polling restarts do not reset it
  always_ff @(posedge clk) begin
    if (reset || state_q == BEE_IDLE) begin
      wd_q <= '0;
      wd_hit_q <= 1'b0;
    end else if (state_q == BEE_POLL && !wd_hit_q) begin
      wd_q <= wd_q + 1'b1;
      wd_hit_q <= (wd_q >= to_cw(WRITE_MAX_CYC));
    end
  end
  wire timeout_now = wd_hit_q && !end_seen;

  // pin drive, registered
  // gate and data stay put one cycle after the strobe rises, so the latched byte keeps its hold time
  wire rd_phase = (state_d == BEE_RD) || (state_d == BEE_POLL) || (state_d == BEE_WAIT && state_q == BEE_WAIT);
  wire clr_phase = (state_d == BEE_CLR);
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_a <= 11'h000;
      mem_chip_sel_n <= 1'b1;
      mem_out_gate_n <= 1'b1;
      mem_out_gate_hv <= 1'b0;
      mem_wr_strobe_n <= 1'b1;
      mem_address_pin_nine_hv <= 1'b0;
      mem_dq_o <= 8'h00;
      mem_dq_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_timeout <= 1'b0;
      mem_addr <= 1'b0;
    end else begin
      mem_a <= take ? req_addr : a_q;
      mem_address_pin_nine_hv <= take ? req_id_area : (state_d != BEE_IDLE && idsel_q);
      mem_chip_sel_n <= (state_d == BEE_IDLE) || (state_d == BEE_DONE);
      mem_out_gate_n <= !rd_phase;
      mem_out_gate_hv <= clr_phase;
      mem_wr_strobe_n <= !((state_d == BEE_WR) || clr_phase) || !wr_ok;
      mem_dq_o <= take ? req_wdata : wdata_q;
      mem_dq_oe <= (state_d == BEE_WR) || (state_q == BEE_WR);
      // ready must not follow req_op: a ready raised for a read would let an early write through
      req_ready <= (state_d == BEE_IDLE) && !take && por_done_q;
      rsp_valid <= (state_d == BEE_DONE);
      rsp_timeout <= (state_d == BEE_DONE) && timeout_now;
      mem_addr <= (state_d != BEE_IDLE);
      if (state_q == BEE_RD && cnt_zero) rsp_rdata <= dq_s2_q;
      else if (state_q == BEE_POLL && state_d == BEE_DONE) rsp_rdata <= dq_s2_q;
    end
  end

  a_no_drive_read: assert property (@(posedge clk) disable iff (reset)
    !mem_out_gate_n |-> !mem_dq_oe) else $error("host drives data while gate low");
  a_write_gate_high: assert property (@(posedge clk) disable iff (reset)
    !mem_wr_strobe_n |-> (mem_out_gate_n && !mem_chip_sel_n)) else $error("strobe without select or gate high");
  a_por_blocks_wr: assert property (@(posedge clk) disable iff (reset)
    !por_done_q |-> mem_wr_strobe_n) else $error("write before power-on delay");
  a_data_stable_wr: assert property (@(posedge clk) disable iff (reset)
    (!mem_wr_strobe_n && !mem_out_gate_hv) |=> $stable(mem_dq_o) || mem_wr_strobe_n) else $error("data moved in pulse");
  a_addr_stable_cyc: assert property (@(posedge clk) disable iff (reset)
    (!mem_chip_sel_n && !$rose(mem_chip_sel_n) && !$fell(mem_chip_sel_n)) |-> $stable(mem_a)) else $error("address moved");
  a_no_next_busy: assert property (@(posedge clk) disable iff (reset)
    (state_q == BEE_POLL && !end_seen && !wd_hit_q) |=> state_q == BEE_POLL) else $error("left poll while busy");
  a_clear_hv: assert property (@(posedge clk) disable iff (reset)
    mem_out_gate_hv |-> (!mem_chip_sel_n && !mem_dq_oe)) else $error("clear without select");
  a_id_held: assert property (@(posedge clk) disable iff (reset)
    (state_q == BEE_WR) |-> mem_address_pin_nine_hv == idsel_q) else $error("id pin changed");
  a_poll_gives_up: assert property (@(posedge clk) disable iff (reset)
    (state_q == BEE_POLL && wr_timed_q && cnt_zero) |=> state_q == BEE_DONE) else $error("poll did not give up");
  a_timeout_pair: assert property (@(posedge clk) disable iff (reset)
    rsp_timeout |-> rsp_valid) else $error("timeout flag without response");

  c_read: cover property (@(posedge clk) state_q == BEE_RD ##[1:20] rsp_valid);
  c_write: cover property (@(posedge clk) state_q == BEE_WR ##[1:1000] state_q == BEE_POLL);
  c_clear: cover property (@(posedge clk) state_q == BEE_CLR);
  c_timeout: cover property (@(posedge clk) rsp_valid && rsp_timeout);
endmodule // bee_host
`default_nettype wire

// ### bee_map.svh
`ifndef BEE_MAP_SVH
`define BEE_MAP_SVH
`define BEE_CLK_HZ 25000000
`define BEE_WRITE_CYCLE_US 1000
`define BEE_POWER_ON_US 5000
`define BEE_CLEAR_PULSE_US 10000
`define BEE_READ_ACCESS_NS 250
`define BEE_WRITE_PULSE_NS 120
`define BEE_ID_BASE 11'h7e0
`define BEE_MSB 7
`endif

// ### bee_pkg.sv
`default_nettype none
package bee_pkg;
  typedef enum logic [6:0] {
    BEE_IDLE = 7'h01,
    BEE_RD = 7'h02,
    BEE_WR = 7'h04,
    BEE_WAIT = 7'h08,
    BEE_POLL = 7'h10,
    BEE_CLR = 7'h20,
    BEE_DONE = 7'h40
  } bee_state_t;
  typedef enum logic [1:0] {
    BEE_OP_READ = 2'h0,
    BEE_OP_WRITE = 2'h1,
    BEE_OP_CLEAR = 2'h2
  } bee_op_t;
endpackage
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench;
  import bee_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {bee_op_t op; logic id; logic [10:0] ad; logic [7:0] wd; logic [7:0] ex;} bee_row_t;
  logic clk = 0, reset = 1, req_valid = 0, req_id_area = 0, stall = 0, tmo;
  bee_op_t req_op = BEE_OP_READ;
  logic [10:0] req_addr = 11'h000;
  logic [7:0] req_wdata = 8'h00, dq_last = 8'h00, got;
  wire req_ready, rsp_valid, rsp_timeout, cs_n, oe_n, oe_hv, we_n, id_hv, dq_oe, drv, rdy, busy_act;
  wire [7:0] rsp_rdata, dq_o, q, dq;
  wire [10:0] a;
  int fails = 0, n_checks = 0, cyc = 0;
  bee_row_t rows [11] = '{'{BEE_OP_WRITE, 1'b0, 11'h005, 8'ha5, 8'h00}, '{BEE_OP_READ, 1'b0, 11'h005, 8'h00, 8'ha5},
    '{BEE_OP_WRITE, 1'b0, 11'h7ff, 8'h3c, 8'h00}, '{BEE_OP_READ, 1'b0, 11'h7ff, 8'h00, 8'h3c},
    '{BEE_OP_WRITE, 1'b1, 11'h7e0, 8'h5a, 8'h00}, '{BEE_OP_READ, 1'b1, 11'h7e0, 8'h00, 8'h5a},
    '{BEE_OP_READ, 1'b0, 11'h7e0, 8'h00, 8'h00}, '{BEE_OP_WRITE, 1'b0, 11'h005, 8'h0f, 8'h00},
    '{BEE_OP_READ, 1'b0, 11'h005, 8'h00, 8'h0f}, '{BEE_OP_CLEAR, 1'b0, 11'h000, 8'h00, 8'h00},
    '{BEE_OP_READ, 1'b0, 11'h005, 8'h00, 8'hff}};
  always #20 clk = ~clk;
  // released bus shows the inverse of its last level, never a lucky match
  assign dq = dq_oe ? dq_o : drv ? q : ~dq_last;
  always @(posedge clk) dq_last <= dq;
  bee_host #(.POWER_ON_CYC(50), .WRITE_MAX_CYC(200), .CLEAR_CYC(50), .USE_BUSY_PIN(1'b1)) i_bee_host (
    .clk(clk), .reset(reset), .req_valid(req_valid), .req_op(req_op), .req_id_area(req_id_area),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .mem_addr(busy_act), .mem_a(a), .mem_chip_sel_n(cs_n),
    .mem_out_gate_n(oe_n), .mem_out_gate_hv(oe_hv), .mem_wr_strobe_n(we_n), .mem_address_pin_nine_hv(id_hv),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq), .mem_ready_busy_n(rdy));
  bee_dev_model i_bee_dev_model (.clk(clk), .reset(reset), .stall(stall), .a(a), .cs_n(cs_n), .oe_n(oe_n),
    .oe_hv(oe_hv), .we_n(we_n), .address_pin_nine_hv(id_hv), .dq(dq), .drv(drv), .q(q), .rdy(rdy));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded waits only; a lost answer counts as a mismatch
  // request held until ready is sampled high at a rising edge
  task automatic do_op(input bee_op_t op, input logic id, input logic [10:0] ad, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_id_area <= id;
    req_addr <= ad;
    req_wdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 5000);
    req_valid <= 1'b0;
    if (n >= 5000) fails++;
    @(negedge clk);
    chk("op active", 8'h01, {7'h0, busy_act});
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) fails++;
    got = rsp_rdata;
    tmo = rsp_timeout;
    repeat (2) @(negedge clk);
    chk("op idle", 8'h00, {7'h0, busy_act});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    chk("select idle", 8'h01, {7'h0, cs_n});
    chk("data drive idle", 8'h00, {7'h0, dq_oe});
    reset <= 1'b0;
    repeat (3) @(negedge clk);
    chk("ready before delay", 8'h00, {7'h0, req_ready});
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].id, rows[i].ad, rows[i].wd);
      if (rows[i].op == BEE_OP_READ) chk("read data", rows[i].ex, got);
      else chk("timeout", rows[i].ex, {7'h0, tmo});
    end
    $display("table test done");
    @(posedge clk) stall <= 1'b1;
    do_op(BEE_OP_WRITE, 1'b0, 11'h123, 8'h77);
    chk("watchdog", 8'h01, {7'h0, tmo});
    @(posedge clk) stall <= 1'b0;
    repeat (40) @(negedge clk);
    do_op(BEE_OP_READ, 1'b0, 11'h123, 8'h00);
    chk("after stall", 8'h77, got);
    $display("stall test done");
    @(posedge clk) reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(negedge clk);
    chk("ready after reset", 8'h00, {7'h0, req_ready});
    do_op(BEE_OP_READ, 1'b0, 11'h123, 8'h00);
    chk("after reset", 8'h77, got);
    $display("reset test done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
